// [igb_lane.sv]
// Gearbox package and one serial lane: double-edge capture and word alignment
`timescale 1ns/1ps

package igb_pkg;
    // Operating modes selected by the core
    typedef enum logic [1:0] {
        IGB_MODE_VIDEO7,
        IGB_MODE_BY8,
        IGB_MODE_DUAL4
    } igb_mode_e;

    // Word widths per mode
    localparam logic [3:0] IGB_WIDTH_VIDEO7 = 4'h7;
    localparam logic [3:0] IGB_WIDTH_BY8 = 4'h8;
    localparam logic [3:0] IGB_WIDTH_BY4 = 4'h4;

    // Shift window and fill counter sizes
    localparam int IGB_SHIFT_W = 16;
    localparam int IGB_FILL_W = 5;
    localparam logic [4:0] IGB_BITS_PER_CYCLE = 5'h2;
    localparam logic [4:0] IGB_SLIP_BITS = 5'h1;
    localparam logic [7:0] IGB_WORD_RESET = 8'h00;
endpackage

module igb_lane
    import igb_pkg::*;
(
    // Fast link side
    input wire logic fast_clk_i,
    input wire logic rst_i,
    input wire logic data_i,
    // Control from the alignment logic
    input wire logic [3:0] width_i,
    input wire logic slip_i,
    // Assembled word
    output logic [7:0] word_o,
    output logic word_toggle_o
);

    // ********************************************
    // Stage one: capture on both clock edges
    // ********************************************
    logic rise_reg;
    logic fall_reg;

    always_ff @(posedge fast_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rise_reg <= 1'b0;
        else
            rise_reg <= data_i;
    end

    always_ff @(negedge fast_clk_i or posedge rst_i)
    begin
        if (rst_i)
            fall_reg <= 1'b0;
        else
            fall_reg <= data_i;
    end

    // ********************************************
    // Stage two: word assembly and boundary slip
    // ********************************************
    function automatic logic [7:0] extract(input logic [IGB_SHIFT_W-1:0] sr, input logic [4:0] pos,
                                           input logic [3:0] width);
        logic [IGB_SHIFT_W-1:0] shifted;
        logic [7:0] mask;
        shifted = sr >> pos;
        mask = 8'(({8'h00, 8'hFF} << width) >> 8);
        extract = shifted[7:0] & mask;
    endfunction

    logic [IGB_SHIFT_W-1:0] shift_reg;
    logic [IGB_SHIFT_W-1:0] shift_next;
    logic [IGB_FILL_W-1:0] fill_reg;
    logic [IGB_FILL_W-1:0] fill_next;
    logic [7:0] word_reg;
    logic toggle_reg;

    // Earlier bit (rising edge) is older, so it lands above the falling one
    wire [IGB_FILL_W-1:0] fill_sum = fill_reg + IGB_BITS_PER_CYCLE;
    wire [IGB_FILL_W-1:0] width_ext = {1'b0, width_i};
    wire emit = fill_sum >= width_ext;
    wire [IGB_FILL_W-1:0] fill_left = emit ? fill_sum - width_ext : fill_sum;
    // A slip drops the oldest pending bit, moving the boundary by one
    wire do_slip = slip_i && (fill_left != '0);

    assign shift_next = {shift_reg[IGB_SHIFT_W-3:0], rise_reg, fall_reg};
    assign fill_next = do_slip ? fill_left - IGB_SLIP_BITS : fill_left;

    always_ff @(posedge fast_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            shift_reg <= '0;
            fill_reg <= '0;
        end
        else
        begin
            shift_reg <= shift_next;
            fill_reg <= fill_next;
        end
    end

    // Word hold stays still until the next emit so the slow side can read it
    always_ff @(posedge fast_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            word_reg <= IGB_WORD_RESET;
            toggle_reg <= 1'b0;
        end
        else if (emit)
        begin
            word_reg <= extract(shift_next, fill_left, width_i);
            toggle_reg <= ~toggle_reg;
        end
    end

    assign word_o = word_reg;
    assign word_toggle_o = toggle_reg;

endmodule // igb_lane

// [igb_gearbox.sv]
// Input gearbox top: two lanes, alignment control and slow-side output stage
`timescale 1ns/1ps

module igb_gearbox
    import igb_pkg::*;
(
    // System side
    input wire logic clk_i,
    input wire logic rst_i,
    // Fast link side
    input wire logic fast_clk_i,
    input wire logic data_first_i,
    input wire logic data_third_i,
    // Core control
    input igb_mode_e mode_i,
    input wire logic word_align_request_i,
    input wire logic align_select_i,
    // Parallel output
    output logic [7:0] q_o,
    output logic q_valid_o
);

    // ********************************************
    // Core-side alignment request capture
    // ********************************************
    logic align_tog_reg;
    logic align_sel_reg;

    // Select is held in a register so the fast side reads a stable value
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            align_tog_reg <= 1'b0;
            align_sel_reg <= 1'b0;
        end
        else if (word_align_request_i)
        begin
            align_tog_reg <= ~align_tog_reg;
            align_sel_reg <= align_select_i;
        end
    end

    // ********************************************
    // Crossing into the fast domain
    // ********************************************
    igb_mode_e mode_s1_reg;
    igb_mode_e mode_s2_reg;
    logic align_s1_reg;
    logic align_s2_reg;
    logic align_s3_reg;

    always_ff @(posedge fast_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_s1_reg <= IGB_MODE_VIDEO7;
            mode_s2_reg <= IGB_MODE_VIDEO7;
            align_s1_reg <= 1'b0;
            align_s2_reg <= 1'b0;
            align_s3_reg <= 1'b0;
        end
        else
        begin
            mode_s1_reg <= mode_i;
            mode_s2_reg <= mode_s1_reg;
            align_s1_reg <= align_tog_reg;
            align_s2_reg <= align_s1_reg;
            align_s3_reg <= align_s2_reg;
        end
    end

    // ********************************************
    // Alignment control block
    // ********************************************
    function automatic logic [3:0] mode_width(input igb_mode_e mode);
        case (mode)
            IGB_MODE_VIDEO7: mode_width = IGB_WIDTH_VIDEO7;
            IGB_MODE_BY8: mode_width = IGB_WIDTH_BY8;
            IGB_MODE_DUAL4: mode_width = IGB_WIDTH_BY4;
            default: mode_width = IGB_WIDTH_BY8;
        endcase
    endfunction

    // Update strobe is one fast cycle; the select has been stable for two
    wire fast_dual = (mode_s2_reg == IGB_MODE_DUAL4);
    wire update = align_s2_reg ^ align_s3_reg;
    wire slip_first = update && (!fast_dual || !align_sel_reg);
    wire slip_third = update && fast_dual && align_sel_reg;
    wire [3:0] width_first = mode_width(mode_s2_reg);

    // ********************************************
    // Serial lanes
    // ********************************************
    logic [7:0] word_first;
    logic [7:0] word_third;
    logic tog_first;
    logic tog_third;

    igb_lane u_lane_first (
        .fast_clk_i(fast_clk_i),
        .rst_i(rst_i),
        .data_i(data_first_i),
        .width_i(width_first),
        .slip_i(slip_first),
        .word_o(word_first),
        .word_toggle_o(tog_first)
    );

    igb_lane u_lane_third (
        .fast_clk_i(fast_clk_i),
        .rst_i(rst_i),
        .data_i(data_third_i),
        .width_i(IGB_WIDTH_BY4),
        .slip_i(slip_third),
        .word_o(word_third),
        .word_toggle_o(tog_third)
    );

    // ********************************************
    // Crossing back into the system domain
    // ********************************************
    logic first_s1_reg;
    logic first_s2_reg;
    logic first_s3_reg;
    logic third_s1_reg;
    logic third_s2_reg;
    logic third_s3_reg;
    igb_mode_e mode_sys_reg;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            first_s1_reg <= 1'b0;
            first_s2_reg <= 1'b0;
            first_s3_reg <= 1'b0;
            third_s1_reg <= 1'b0;
            third_s2_reg <= 1'b0;
            third_s3_reg <= 1'b0;
            mode_sys_reg <= IGB_MODE_VIDEO7;
        end
        else
        begin
            first_s1_reg <= tog_first;
            first_s2_reg <= first_s1_reg;
            first_s3_reg <= first_s2_reg;
            third_s1_reg <= tog_third;
            third_s2_reg <= third_s1_reg;
            third_s3_reg <= third_s2_reg;
            mode_sys_reg <= mode_i;
        end
    end

    // ********************************************
    // Stage three: output mapping
    // ********************************************
    // Word holds are read only after their toggle has crossed, so they are stable
    wire new_first = first_s2_reg ^ first_s3_reg;
    wire new_third = third_s2_reg ^ third_s3_reg;
    wire sys_dual = (mode_sys_reg == IGB_MODE_DUAL4);

    logic [7:0] q_reg;
    logic [7:0] q_next;
    logic q_valid_reg;

    always_comb
    begin
        q_next = q_reg;
        if (sys_dual)
        begin
            if (new_first)
                q_next[7:4] = word_first[3:0];
            if (new_third)
                q_next[3:0] = word_third[3:0];
        end
        else if (new_first)
        begin
            q_next = word_first;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q_reg <= IGB_WORD_RESET;
            q_valid_reg <= 1'b0;
        end
        else
        begin
            q_reg <= q_next;
            q_valid_reg <= new_first || (sys_dual && new_third);
        end
    end

    assign q_o = q_reg;
    assign q_valid_o = q_valid_reg;

endmodule // igb_gearbox

// [igb_gearbox_props.sv]
// Port checks for the input gearbox top
`timescale 1ns/1ps

module igb_gearbox_props
    import igb_pkg::*;
(
    // System side
    input wire logic clk_i,
    input wire logic rst_i,
    // Core side
    input igb_mode_e mode_i,
    input wire logic [7:0] q_o,
    input wire logic q_valid_o
);
    // ****************************************
    // Cycles since reset release
    // ****************************************
    logic [7:0] run_cnt_reg;
    logic [7:0] run_cnt_next;
    assign run_cnt_next = (run_cnt_reg == 8'hFF) ? run_cnt_reg : run_cnt_reg + 8'h01;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            run_cnt_reg <= 8'h00;
        else
            run_cnt_reg <= run_cnt_next;
    end

    rst_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> q_o == 8'h00) else $error("word not clear after reset");
    rst_valid_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> !q_valid_o) else $error("valid after reset");
    // Dual mode can emit two fast cycles after release, so the floor sits just under that
    pipe_depth_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q_valid_o |-> run_cnt_reg >= 8'h07) else $error("word too early after reset");
    valid_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q_valid_o && mode_i != IGB_MODE_DUAL4 |=> !q_valid_o [*8]) else $error("valid pulse too long");
    // Lanes may sit one fast cycle apart, so nibble pulses can come four cycles apart
    valid_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q_valid_o && mode_i == IGB_MODE_DUAL4 |=> !q_valid_o [*3]) else $error("nibble valid too long");
    word_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !q_valid_o |-> $stable(q_o)) else $error("word changed without valid");
    word_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q_valid_o |-> ##[1:30] q_valid_o) else $error("word stream stalled");
    nibble_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q_valid_o && mode_i == IGB_MODE_DUAL4 |-> ##[1:15] q_valid_o) else $error("nibble stream slow");
    video_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q_valid_o && mode_i == IGB_MODE_VIDEO7 |-> !q_o[7]) else $error("video word uses bit 7");
endmodule // igb_gearbox_props

// [igb_serial_src.sv]
// Serial source model: repeating pattern on both fast clock edges
`timescale 1ns/1ps

module igb_serial_src (
    // Fast link side
    input wire logic fast_clk_i,
    // Pattern from the bench
    input wire logic [7:0] pat_a_i,
    input wire logic [7:0] pat_c_i,
    input wire logic [3:0] len_i,
    // Serial lanes
    output logic data_first_o,
    output logic data_third_o
);
    int k = 0;
    logic [3:0] idx;
    initial data_first_o = 1'b0;
    initial data_third_o = 1'b0;
    // Bits move mid-way between edges, as after the input delay line
    always @(fast_clk_i)
    begin
        #12;
        if (k >= int'(len_i))
            k = 0;
        idx = len_i - 4'h1 - 4'(k);
        data_first_o = pat_a_i[idx[2:0]];
        data_third_o = pat_c_i[idx[2:0]];
        k++;
    end
endmodule // igb_serial_src

// [igb_gearbox_bench.sv]
// Self-checking bench for the input gearbox top
`timescale 1ns/1ps

module igb_gearbox_bench;
    import igb_pkg::*;
    logic clk_i = 1'b0;
    logic fast_clk_i = 1'b0;
    logic rst_i = 1'b1;
    igb_mode_e mode_i = IGB_MODE_BY8;
    logic word_align_request_i = 1'b0;
    logic align_select_i = 1'b0;
    logic data_first_i;
    logic data_third_i;
    logic [7:0] q_o;
    logic q_valid_o;
    logic [7:0] pat_a = 8'hB4;
    logic [7:0] pat_c = 8'h01;
    logic [3:0] len = 4'h8;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    initial forever #5 clk_i = ~clk_i;
    initial
    begin
        #7;
        forever #24 fast_clk_i = ~fast_clk_i;
    end

    igb_gearbox dut (.clk_i(clk_i), .rst_i(rst_i), .fast_clk_i(fast_clk_i), .data_first_i(data_first_i),
        .data_third_i(data_third_i), .mode_i(mode_i), .word_align_request_i(word_align_request_i),
        .align_select_i(align_select_i), .q_o(q_o), .q_valid_o(q_valid_o));
    igb_serial_src src (.fast_clk_i(fast_clk_i), .pat_a_i(pat_a), .pat_c_i(pat_c), .len_i(len),
        .data_first_o(data_first_i), .data_third_o(data_third_i));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [7:0] rotl(input logic [7:0] v, input logic [3:0] w);
        logic [7:0] m;
        m = (8'h01 << w) - 8'h01;
        return ((v << 1) | (v >> (w - 4'h1))) & m;
    endfunction

    // Stream phase after reset is free, so any rotation of the pattern is a good word
    function automatic logic isrot(input logic [7:0] v, input logic [7:0] p, input logic [3:0] w);
        logic [7:0] r;
        r = p;
        isrot = 1'b0;
        repeat (w)
        begin
            if (v === r)
                isrot = 1'b1;
            r = rotl(r, w);
        end
    endfunction

    task automatic next_word();
        int n;
        n = 0;
        @(negedge clk_i);
        while (q_valid_o !== 1'b1 && n < 60)
        begin
            n++;
            @(negedge clk_i);
        end
        chk("word arrival", 8'h01, {7'h00, q_valid_o});
    endtask

    task automatic t_mode(input igb_mode_e m, input logic [7:0] pa, input logic [7:0] pc, input logic [3:0] w,
        input logic sel);
        logic [7:0] exp;
        int k;
        @(negedge clk_i);
        pat_a = pa;
        pat_c = pc;
        len = w;
        rst_i = 1'b1;
        mode_i = m;
        repeat (20) @(negedge clk_i);
        chk("reset word", 8'h00, q_o);
        rst_i = 1'b0;
        @(negedge clk_i);
        chk("released word", 8'h00, q_o);
        chk("released valid", 8'h00, {7'h00, q_valid_o});
        repeat (3) next_word();
        if (m == IGB_MODE_DUAL4)
        begin
            chk("first lane", 8'h01, {7'h00, isrot({4'h0, q_o[7:4]}, pa, w)});
            chk("third lane", 8'h01, {7'h00, isrot({4'h0, q_o[3:0]}, pc, w)});
            if (sel)
                exp = {q_o[7:4], 4'h0} | rotl({4'h0, q_o[3:0]}, w);
            else
                exp = (rotl({4'h0, q_o[7:4]}, w) << 4) | {4'h0, q_o[3:0]};
        end
        else
        begin
            chk("word", 8'h01, {7'h00, isrot(q_o, pa, w)});
            exp = rotl(q_o, w);
        end
        // A request may fall where no bit is pending, so a few are allowed
        k = 0;
        do
        begin
            @(negedge clk_i);
            word_align_request_i = 1'b1;
            align_select_i = sel;
            @(negedge clk_i);
            word_align_request_i = 1'b0;
            repeat (4) next_word();
            k++;
        end while (q_o !== exp && k < 4);
        chk("aligned word", exp, q_o);
    endtask

    // ****************************************
    // Main sequence and hang guard
    // ****************************************
    initial
    begin
        t_mode(IGB_MODE_BY8, 8'hB4, 8'h00, 4'h8, 1'b0);
        t_mode(IGB_MODE_VIDEO7, 8'h4B, 8'h00, 4'h7, 1'b0);
        t_mode(IGB_MODE_DUAL4, 8'h0C, 8'h01, 4'h4, 1'b1);
        t_mode(IGB_MODE_DUAL4, 8'h0C, 8'h01, 4'h4, 1'b0);
        close_out();
    end

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            close_out();
        end
    end
endmodule // igb_gearbox_bench

bind igb_gearbox igb_gearbox_props u_props (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .q_o(q_o),
    .q_valid_o(q_valid_o));
